// >>> hdl/mip_pkg.sv
// mip_pkg: constants and types of the monitor two-wire slave port
// assumes one 200 MHz core clock; straps arrive as two-bit level codes
package mip_pkg;
	localparam int CLK_PERIOD_NS = 5;
	localparam int TIMEOUT_MS = 28;
	localparam int TIMEOUT_CYCLES = TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
	localparam int SPIKE_FS_NS = 50;
	localparam int SPIKE_HS_NS = 10;
	localparam int SPIKE_FS_CYCLES = SPIKE_FS_NS / CLK_PERIOD_NS;
	localparam int SPIKE_HS_CYCLES = SPIKE_HS_NS / CLK_PERIOD_NS;
	localparam logic [2:0] ADDR_PREFIX = 3'h4;
	localparam logic [7:0] GC_ADDR_BYTE = 8'h00;
	localparam logic [7:0] GC_RESET_CMD = 8'h06;
	localparam logic [4:0] HS_CODE_PREFIX = 5'h01;
	localparam logic [7:0] PTR_CONFIG = 8'h00;
	localparam logic [7:0] PTR_SHUNT = 8'h01;
	localparam logic [7:0] PTR_BUS = 8'h02;
	localparam logic [7:0] PTR_POWER = 8'h03;
	localparam logic [7:0] PTR_CURRENT = 8'h04;
	localparam logic [7:0] PTR_CALIB = 8'h05;
	localparam logic [15:0] CONFIG_RESET = 16'h399f;
	localparam logic [15:0] CALIB_RESET = 16'h0000;
	localparam int CFG_RST_BIT = 15;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	typedef enum logic [2:0] {
		MIP_IDLE = 3'b000, MIP_RX = 3'b001, MIP_ACK = 3'b010,
		MIP_TX = 3'b011, MIP_MACK = 3'b100, MIP_IGNORE = 3'b101
	} mip_state_t;
	typedef enum logic [2:0] {
		MIP_K_ADDR = 3'b000, MIP_K_PTR = 3'b001, MIP_K_WHI = 3'b010,
		MIP_K_WLO = 3'b011, MIP_K_GC = 3'b100, MIP_K_READ = 3'b101, MIP_K_DONE = 3'b110
	} mip_kind_t;
endpackage

// >>> hdl/mip_reg_if.sv
// mip_reg_if: link between the bus engine and the register bank
// assumes both ends run on the core clock
`timescale 1ns/1ps
`default_nettype none
interface mip_reg_if;
	logic wr;
	logic [7:0] ptr;
	logic [15:0] wdata;
	logic dev_rst;
	logic [15:0] rdata;
	logic [15:0] cfg_q;
	logic [15:0] calib_q;
	modport ctl (output wr, ptr, wdata, dev_rst, input rdata, cfg_q, calib_q);
	modport bank (input wr, ptr, wdata, dev_rst, output rdata, cfg_q, calib_q);
endinterface
`default_nettype wire

// >>> hdl/mip_glitch_filter.sv
// mip_glitch_filter: two-flop synchroniser and spike suppressor for one bus line
// assumes an idle-high open-drain line sampled by the core clock
`timescale 1ns/1ps
`default_nettype none
module mip_glitch_filter (
	// clock and reset
	input wire logic clk_in,
	input wire logic resetn_in,
	// line and mode
	input wire logic raw_in,
	input wire logic hs_in,
	output logic clean_out
);
	logic meta;
	logic sync;
	logic [3:0] run;
	logic [3:0] limit;

	// shorter window in high-speed mode; both stay well under a 2.56 MHz high phase
	assign limit = hs_in ? 4'(mip_pkg::SPIKE_HS_CYCLES) : 4'(mip_pkg::SPIKE_FS_CYCLES);

	always_ff @(posedge clk_in)
	begin
		if (!resetn_in)
		begin
			meta <= 1'b1;
			sync <= 1'b1;
		end
		else
		begin
			meta <= raw_in;
			sync <= meta;
		end
	end

	// a level must persist for limit cycles before it is believed
	always_ff @(posedge clk_in)
	begin
		if (!resetn_in)
		begin
			run <= 4'h0;
			clean_out <= 1'b1;
		end
		else if (sync == clean_out)
			run <= 4'h0;
		else if (run >= limit - 4'h1)
		begin
			clean_out <= sync;
			run <= 4'h0;
		end
		else
			run <= run + 4'h1;
	end
endmodule // mip_glitch_filter
`default_nettype wire

// >>> hdl/mip_reg_bank.sv
// mip_reg_bank: writable configuration and calibration, read multiplexer
// assumes measurement results arrive on the core clock
`timescale 1ns/1ps
`default_nettype none
module mip_reg_bank (
	// clock and reset
	input wire logic clk_in,
	input wire logic resetn_in,
	// measurement results
	input wire logic [15:0] shunt_in,
	input wire logic [15:0] bus_in,
	input wire logic [15:0] current_in,
	input wire logic [15:0] power_in,
	// engine side
	mip_reg_if.bank regs
);
	logic calibrated;

	assign calibrated = (regs.calib_q != 16'h0000);

	// reset beats a coinciding write, so the reset bit never stays set
	always_ff @(posedge clk_in)
	begin
		if (!resetn_in || regs.dev_rst)
		begin
			regs.cfg_q <= mip_pkg::CONFIG_RESET;
			regs.calib_q <= mip_pkg::CALIB_RESET;
		end
		else if (regs.wr && regs.ptr == mip_pkg::PTR_CONFIG)
			regs.cfg_q <= regs.wdata;
		else if (regs.wr && regs.ptr == mip_pkg::PTR_CALIB)
			regs.calib_q <= regs.wdata;
	end

	always_ff @(posedge clk_in)
	begin
		if (!resetn_in)
			regs.rdata <= 16'h0000;
		else if (regs.ptr == mip_pkg::PTR_CONFIG)
			regs.rdata <= regs.cfg_q;
		else if (regs.ptr == mip_pkg::PTR_SHUNT)
			regs.rdata <= shunt_in;
		else if (regs.ptr == mip_pkg::PTR_BUS)
			regs.rdata <= bus_in;
		else if (regs.ptr == mip_pkg::PTR_POWER)
			regs.rdata <= calibrated ? power_in : 16'h0000;
		else if (regs.ptr == mip_pkg::PTR_CURRENT)
			regs.rdata <= calibrated ? current_in : 16'h0000;
		else if (regs.ptr == mip_pkg::PTR_CALIB)
			regs.rdata <= regs.calib_q;
		else
			regs.rdata <= 16'h0000;
	end
endmodule // mip_reg_bank
`default_nettype wire

// >>> hdl/mip_slave.sv
// mip_slave: two-wire slave port of a current and power monitor
// assumes raw bus pins and straps are asynchronous; results come on clk_in
`timescale 1ns/1ps
`default_nettype none
module mip_slave #(
	parameter int TIMEOUT_CYCLES = mip_pkg::TIMEOUT_CYCLES,
	parameter int TO_W = 23
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic resetn_in,
	// two-wire bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic scl_out,
	output logic scl_oe_out,
	output logic sda_out,
	output logic sda_oe_out,
	// address straps as level codes: 0 ground, 1 supply, 2 data, 3 clock
	input wire logic [1:0] addr_strap_high_in,
	input wire logic [1:0] addr_strap_low_in,
	// results from the conversion engine
	input wire logic [15:0] shunt_data_in,
	input wire logic [15:0] bus_data_in,
	input wire logic [15:0] current_data_in,
	input wire logic [15:0] power_data_in,
	// state seen by the rest of the device
	output logic [15:0] config_out,
	output logic [15:0] calib_out,
	output logic hs_mode_out,
	output logic dev_reset_out
);
	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	mip_reg_if regs ();
	mip_pkg::mip_state_t state;
	mip_pkg::mip_kind_t kind;
	mip_pkg::mip_kind_t next_kind;
	logic scl_f;
	logic sda_f;
	logic scl_q;
	logic sda_q;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	logic [3:0] strap_meta;
	logic [3:0] strap_sync;
	logic [6:0] slave_addr;
	logic [3:0] bitcnt;
	logic [7:0] rx_byte;
	logic [7:0] tx_shift;
	logic [15:0] tx_word;
	logic [7:0] hi_byte;
	logic [7:0] pointer;
	logic tx_low;
	logic mack_ok;
	logic sda_drive;
	logic hs_mode;
	logic wr_pulse;
	logic [15:0] wr_data;
	logic rst_pulse;
	logic [TO_W-1:0] to_cnt;
	logic timeout;
	logic byte_end;
	logic addr_hit;
	logic gc_hit;
	logic hs_code;
	logic gc_reset;
	logic ack_now;

	// ----------------------------------------------------------------
	// line conditioning
	// ----------------------------------------------------------------
	mip_glitch_filter u_scl_filter (
		.clk_in(clk_in),
		.resetn_in(resetn_in),
		.raw_in(scl_in),
		.hs_in(hs_mode),
		.clean_out(scl_f)
	);

	mip_glitch_filter u_sda_filter (
		.clk_in(clk_in),
		.resetn_in(resetn_in),
		.raw_in(sda_in),
		.hs_in(hs_mode),
		.clean_out(sda_f)
	);

	always_ff @(posedge clk_in)
	begin
		if (!resetn_in)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end
		else
		begin
			scl_q <= scl_f;
			sda_q <= sda_f;
		end
	end

	assign scl_rise = scl_f && !scl_q;
	assign scl_fall = !scl_f && scl_q;
	// data moving under a high clock is framing, never data
	assign start_cond = scl_f && scl_q && sda_q && !sda_f;
	assign stop_cond = scl_f && scl_q && !sda_q && sda_f;

	// ----------------------------------------------------------------
	// address straps
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in)
	begin
		if (!resetn_in)
		begin
			strap_meta <= 4'h0;
			strap_sync <= 4'h0;
		end
		else
		begin
			strap_meta <= {addr_strap_high_in, addr_strap_low_in};
			strap_sync <= strap_meta;
		end
	end

	// straps are taken afresh at each start, so late strap changes apply next time
	always_ff @(posedge clk_in)
	begin
		if (!resetn_in)
			slave_addr <= {mip_pkg::ADDR_PREFIX, 4'h0};
		else if (start_cond)
			slave_addr <= {mip_pkg::ADDR_PREFIX, strap_sync};
	end

	// ----------------------------------------------------------------
	// byte decode
	// ----------------------------------------------------------------
	assign byte_end = (state == mip_pkg::MIP_RX) && scl_fall && (bitcnt == mip_pkg::BITS_PER_BYTE);
	assign addr_hit = (kind == mip_pkg::MIP_K_ADDR) && (rx_byte[7:1] == slave_addr);
	assign gc_hit = (kind == mip_pkg::MIP_K_ADDR) && (rx_byte == mip_pkg::GC_ADDR_BYTE);
	assign hs_code = (kind == mip_pkg::MIP_K_ADDR) && (rx_byte[7:3] == mip_pkg::HS_CODE_PREFIX);
	assign gc_reset = (kind == mip_pkg::MIP_K_GC) && (rx_byte == mip_pkg::GC_RESET_CMD);

	always_comb
	begin
		ack_now = 1'b0;
		next_kind = mip_pkg::MIP_K_DONE;
		case (kind)
			mip_pkg::MIP_K_ADDR:
			begin
				ack_now = addr_hit || gc_hit;
				if (gc_hit)
					next_kind = mip_pkg::MIP_K_GC;
				else if (rx_byte[0])
					next_kind = mip_pkg::MIP_K_READ;
				else
					next_kind = mip_pkg::MIP_K_PTR;
			end
			mip_pkg::MIP_K_PTR:
			begin
				ack_now = 1'b1;
				next_kind = mip_pkg::MIP_K_WHI;
			end
			mip_pkg::MIP_K_WHI:
			begin
				ack_now = 1'b1;
				next_kind = mip_pkg::MIP_K_WLO;
			end
			mip_pkg::MIP_K_WLO:
			begin
				ack_now = 1'b1;
				next_kind = mip_pkg::MIP_K_DONE;
			end
			mip_pkg::MIP_K_GC:
			begin
				ack_now = gc_reset;
				next_kind = mip_pkg::MIP_K_DONE;
			end
			default:
			begin
				ack_now = 1'b0;
				next_kind = mip_pkg::MIP_K_DONE;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// stall watchdog
	// ----------------------------------------------------------------
	// any clock edge proves the master is alive; only a frozen clock counts
	always_ff @(posedge clk_in)
	begin
		if (!resetn_in || state == mip_pkg::MIP_IDLE || scl_rise || scl_fall || start_cond)
			to_cnt <= '0;
		else if (!timeout)
			to_cnt <= to_cnt + TO_W'(1);
	end

	assign timeout = (to_cnt == TO_W'(TIMEOUT_CYCLES - 1));

	// ----------------------------------------------------------------
	// bit and byte engine
	// ----------------------------------------------------------------
	// the data line is only pulled low after a falling clock edge; start, stop and timeout release it at once
	always_ff @(posedge clk_in)
	begin
		if (!resetn_in)
		begin
			state <= mip_pkg::MIP_IDLE;
			kind <= mip_pkg::MIP_K_ADDR;
			bitcnt <= 4'h0;
			rx_byte <= 8'h00;
			tx_shift <= 8'h00;
			tx_low <= 1'b0;
			mack_ok <= 1'b0;
			sda_drive <= 1'b0;
		end
		else if (start_cond)
		begin
			state <= mip_pkg::MIP_RX;
			kind <= mip_pkg::MIP_K_ADDR;
			bitcnt <= 4'h0;
			tx_low <= 1'b0;
			sda_drive <= 1'b0;
		end
		else if (stop_cond || timeout)
		begin
			state <= mip_pkg::MIP_IDLE;
			sda_drive <= 1'b0;
		end
		else
		begin
			case (state)
				mip_pkg::MIP_RX:
				begin
					if (scl_rise && bitcnt != mip_pkg::BITS_PER_BYTE)
					begin
						rx_byte <= {rx_byte[6:0], sda_f};
						bitcnt <= bitcnt + 4'h1;
					end
					else if (byte_end)
					begin
						bitcnt <= 4'h0;
						kind <= next_kind;
						if (ack_now)
						begin
							state <= mip_pkg::MIP_ACK;
							sda_drive <= 1'b1;
						end
						else
							state <= mip_pkg::MIP_IGNORE;
					end
				end
				mip_pkg::MIP_ACK:
				begin
					if (scl_fall)
					begin
						if (kind == mip_pkg::MIP_K_READ)
						begin
							state <= mip_pkg::MIP_TX;
							tx_shift <= tx_word[15:8];
							sda_drive <= !tx_word[15];
							mack_ok <= 1'b0;
						end
						else if (kind == mip_pkg::MIP_K_DONE)
						begin
							state <= mip_pkg::MIP_IGNORE;
							sda_drive <= 1'b0;
						end
						else
						begin
							state <= mip_pkg::MIP_RX;
							sda_drive <= 1'b0;
						end
					end
				end
				mip_pkg::MIP_TX:
				begin
					if (scl_rise)
						bitcnt <= bitcnt + 4'h1;
					else if (scl_fall && bitcnt == mip_pkg::BITS_PER_BYTE)
					begin
						state <= mip_pkg::MIP_MACK;
						bitcnt <= 4'h0;
						sda_drive <= 1'b0;
					end
					else if (scl_fall)
					begin
						tx_shift <= {tx_shift[6:0], 1'b0};
						sda_drive <= !tx_shift[6];
					end
				end
				mip_pkg::MIP_MACK:
				begin
					if (scl_rise)
						mack_ok <= !sda_f;
					else if (scl_fall && mack_ok && !tx_low)
					begin
						state <= mip_pkg::MIP_TX;
						tx_shift <= tx_word[7:0];
						sda_drive <= !tx_word[7];
						tx_low <= 1'b1;
						mack_ok <= 1'b0;
					end
					else if (scl_fall)
						state <= mip_pkg::MIP_IGNORE;
				end
				default:
				begin
					sda_drive <= 1'b0;
				end
			endcase
		end
	end

	// the read word is frozen at the address byte so a mid-read update cannot tear it
	always_ff @(posedge clk_in)
	begin
		if (!resetn_in)
			tx_word <= 16'h0000;
		else if (byte_end && addr_hit && rx_byte[0])
			tx_word <= regs.rdata;
	end

	// ----------------------------------------------------------------
	// pointer, write path and device reset
	// ----------------------------------------------------------------
	// reads never touch the pointer, so repeated reads see one register
	always_ff @(posedge clk_in)
	begin
		if (!resetn_in || rst_pulse)
			pointer <= mip_pkg::PTR_CONFIG;
		else if (byte_end && kind == mip_pkg::MIP_K_PTR)
			pointer <= rx_byte;
	end

	always_ff @(posedge clk_in)
	begin
		if (!resetn_in)
			hi_byte <= 8'h00;
		else if (byte_end && kind == mip_pkg::MIP_K_WHI)
			hi_byte <= rx_byte;
	end

	always_ff @(posedge clk_in)
	begin
		if (!resetn_in)
		begin
			wr_pulse <= 1'b0;
			wr_data <= 16'h0000;
			rst_pulse <= 1'b0;
		end
		else
		begin
			wr_pulse <= byte_end && kind == mip_pkg::MIP_K_WLO;
			if (byte_end && kind == mip_pkg::MIP_K_WLO)
				wr_data <= {hi_byte, rx_byte};
			// config bit 15 and the general-call reset share one path
			rst_pulse <= (byte_end && kind == mip_pkg::MIP_K_WLO
				&& pointer == mip_pkg::PTR_CONFIG
				&& hi_byte[mip_pkg::CFG_RST_BIT - 8]) || (byte_end && gc_reset);
		end
	end

	// ----------------------------------------------------------------
	// high-speed mode
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in)
	begin
		if (!resetn_in || rst_pulse)
			hs_mode <= 1'b0;
		else if (stop_cond)
			hs_mode <= 1'b0;
		else if (byte_end && hs_code)
			hs_mode <= 1'b1;
	end

	// ----------------------------------------------------------------
	// register bank and outputs
	// ----------------------------------------------------------------
	assign regs.wr = wr_pulse;
	assign regs.ptr = pointer;
	assign regs.wdata = wr_data;
	assign regs.dev_rst = rst_pulse;

	mip_reg_bank u_bank (
		.clk_in(clk_in),
		.resetn_in(resetn_in),
		.shunt_in(shunt_data_in),
		.bus_in(bus_data_in),
		.current_in(current_data_in),
		.power_in(power_data_in),
		.regs(regs.bank)
	);

	// slave only: the clock line is never driven, data is open-drain low
	always_ff @(posedge clk_in)
	begin
		if (!resetn_in)
		begin
			scl_out <= 1'b0;
			scl_oe_out <= 1'b0;
			sda_out <= 1'b0;
		end
		else
		begin
			scl_out <= 1'b0;
			scl_oe_out <= 1'b0;
			sda_out <= 1'b0;
		end
	end

	assign sda_oe_out = sda_drive;
	assign hs_mode_out = hs_mode;
	assign dev_reset_out = rst_pulse;
	assign config_out = regs.cfg_q;
	assign calib_out = regs.calib_q;
endmodule // mip_slave
`default_nettype wire

// >>> tb/mip_slave_sva.sv
// mip_slave_chk: pin-level assertions for the two-wire slave port
// sees only the top-level ports; bound into every mip_slave instance
`timescale 1ns/1ps
`default_nettype none
module mip_slave_chk #(
	parameter int TIMEOUT_CYCLES = 2000
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic resetn_in,
	// bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic scl_oe_out,
	input wire logic sda_oe_out,
	// device state
	input wire logic [15:0] config_out,
	input wire logic [15:0] calib_out,
	input wire logic hs_mode_out,
	input wire logic dev_reset_out
);
	// filter latency adds to the engine's own limit, hence the margin
	localparam int TO_MAX = TIMEOUT_CYCLES + 32;
	logic [31:0] still;
	always_ff @(posedge clk_in)
		if (!resetn_in || !sda_oe_out || $changed(scl_in))
			still <= 32'h0;
		else
			still <= still + 32'h1;
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	sequence s_stop;
		scl_in && $rose(sda_in);
	endsequence
	sequence s_powerup;
		config_out == mip_pkg::CONFIG_RESET && calib_out == mip_pkg::CALIB_RESET;
	endsequence
	property p_hs_stop;
		s_stop ##0 hs_mode_out |-> ##[1:30] !hs_mode_out;
	endproperty
	a_hs_stop: assert property (p_hs_stop) else $error("hs mode kept after stop");
	property p_rst_cfg;
		dev_reset_out |-> ##[0:3] s_powerup;
	endproperty
	a_rst_cfg: assert property (p_rst_cfg) else $error("reset left registers");
	property p_pulse;
		dev_reset_out |=> !dev_reset_out;
	endproperty
	a_pulse: assert property (p_pulse) else $error("reset request not a pulse");
	property p_cfg15;
		config_out[15] == 1'b0;
	endproperty
	a_cfg15: assert property (p_cfg15) else $error("reset bit stuck");
	property p_scl_free;
		!scl_oe_out;
	endproperty
	a_scl_free: assert property (p_scl_free) else $error("clock line driven");
	property p_drive_low;
		$rose(sda_oe_out) |-> !scl_in;
	endproperty
	a_drive_low: assert property (p_drive_low) else $error("data pulled in clock high");
	property p_ack_hold;
		$rose(scl_in) && sda_oe_out |-> sda_oe_out [*8];
	endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("data moved in clock high");
	property p_timeout;
		still <= TO_MAX;
	endproperty
	a_timeout: assert property (p_timeout) else $error("stalled bus not released");
	property p_hs_nack;
		$rose(hs_mode_out) |-> !sda_oe_out [*8];
	endproperty
	a_hs_nack: assert property (p_hs_nack) else $error("master code acked");
endmodule // mip_slave_chk
bind mip_slave mip_slave_chk #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) mip_slave_chk_i (
	.clk_in(clk_in), .resetn_in(resetn_in), .scl_in(scl_in), .sda_in(sda_in),
	.scl_oe_out(scl_oe_out), .sda_oe_out(sda_oe_out), .config_out(config_out),
	.calib_out(calib_out), .hs_mode_out(hs_mode_out), .dev_reset_out(dev_reset_out));
`default_nettype wire

// >>> tb/mip_bfm.sv
// mip_bfm: behavioural two-wire bus master driving clock and data
// assumes pull-ups on both wires; q is a quarter bit time in ns
`timescale 1ns/1ps
`default_nettype none
module mip_bfm (
	// lines, high means released
	output logic scl_out,
	output logic sda_out,
	// resolved data wire
	input wire logic sda_in
);
	int q = 100;
	initial
	begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end
	// ----------------------------------------
	// bit and byte tasks
	// ----------------------------------------
	task automatic bitx(input logic b, output logic r);
		sda_out = b;
		#q;
		scl_out = 1'b1;
		#q;
		r = sda_in;
		#q;
		scl_out = 1'b0;
		#q;
	endtask
	// also serves as repeated start, so hs traffic keeps the bus
	task automatic start;
		sda_out = 1'b1;
		#q;
		scl_out = 1'b1;
		#q;
		sda_out = 1'b0;
		#q;
		scl_out = 1'b0;
		#q;
	endtask
	task automatic stop;
		sda_out = 1'b0;
		#q;
		scl_out = 1'b1;
		#q;
		sda_out = 1'b1;
		#q;
	endtask
	task automatic wbyte(input logic [7:0] v, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bitx(v[i], r);
		bitx(1'b1, r);
		ack = !r;
	endtask
	task automatic rbyte(input logic ack, output logic [7:0] v);
		logic r;
		for (int i = 7; i >= 0; i--)
			bitx(1'b1, v[i]);
		bitx(!ack, r);
	endtask
endmodule // mip_bfm
`default_nettype wire

// >>> tb/tb_top.sv
// tb_top: self-checking bench for the two-wire slave port
// assumes mip_bfm drives the bus lines at its own pace, unrelated to clk_in
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk_in;
	logic resetn_in = 1'b0;
	logic [1:0] st_hi = 2'h0;
	logic [1:0] st_lo = 2'h0;
	logic [15:0] shunt = 16'h0, vbus = 16'h0, cur = 16'h0, pwr = 16'h0, cfg, cal;
	logic scl_m, sda_m, scl_oe, sda_oe, scl_o, sda_o, hs, drst, a;
	logic [6:0] adr;
	logic [7:0] h;
	int fails = 0, samples_checked = 0, rst_seen = 0;
	wire scl_w = scl_m & ~scl_oe;
	wire sda_w = sda_m & ~sda_oe;
	mip_slave #(.TIMEOUT_CYCLES(2000)) mip_slave_i (
		.clk_in(clk_in), .resetn_in(resetn_in), .scl_in(scl_w), .sda_in(sda_w),
		.scl_out(scl_o), .scl_oe_out(scl_oe), .sda_out(sda_o), .sda_oe_out(sda_oe),
		.addr_strap_high_in(st_hi), .addr_strap_low_in(st_lo), .shunt_data_in(shunt),
		.bus_data_in(vbus), .current_data_in(cur), .power_data_in(pwr),
		.config_out(cfg), .calib_out(cal), .hs_mode_out(hs), .dev_reset_out(drst));
	mip_bfm mip_bfm_i (.scl_out(scl_m), .sda_out(sda_m), .sda_in(sda_w));
	initial
	begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end
	always @(posedge clk_in)
		if (drst === 1'b1)
			rst_seen <= rst_seen + 1;
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task check(input string nm, input logic [15:0] got, input logic [15:0] want);
		samples_checked++;
		if (got !== want)
		begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", nm, want, got);
		end
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task go(input int n);
		repeat (n) @(posedge clk_in);
	endtask
	// n data bytes; a third one must be refused
	task wr(input logic [7:0] p, input logic [15:0] v, input int n);
		logic k;
		mip_bfm_i.start();
		mip_bfm_i.wbyte({adr, 1'b0}, k);
		check("write address ack", 16'(k), 16'h0001);
		mip_bfm_i.wbyte(p, k);
		check("pointer ack", 16'(k), 16'h0001);
		for (int b = 0; b < n; b++)
		begin
			mip_bfm_i.wbyte(b == 0 ? v[15:8] : b == 1 ? v[7:0] : 8'h5a, k);
			check("data ack", 16'(k), 16'(b < 2));
		end
		mip_bfm_i.stop();
		#4000;
	endtask
	task rd(input string nm, input logic [15:0] want);
		logic k;
		logic [15:0] v;
		mip_bfm_i.start();
		mip_bfm_i.wbyte({adr, 1'b1}, k);
		check("read address ack", 16'(k), 16'h0001);
		mip_bfm_i.rbyte(1'b1, v[15:8]);
		mip_bfm_i.rbyte(1'b0, v[7:0]);
		mip_bfm_i.stop();
		check(nm, v, want);
	endtask
	initial
	begin
		#420000;
		fails++;
		finish_test();
	end
	initial
	begin
		go(8);
		resetn_in <= 1'b1;
		go(8);
		check("config reset", cfg, mip_pkg::CONFIG_RESET);
		check("calib reset", cal, 16'h0000);
		check("flags reset", {11'h0, scl_o, sda_o, scl_oe, hs, sda_oe}, 16'h0000);
		for (int i = 0; i < 16; i++)
		begin
			st_hi <= i[3:2];
			st_lo <= i[1:0];
			go(6);
			adr = {mip_pkg::ADDR_PREFIX, i[3:0]};
			mip_bfm_i.start();
			mip_bfm_i.wbyte({adr, 1'b0}, a);
			mip_bfm_i.stop();
			check("strap address ack", 16'(a), 16'h0001);
		end
		mip_bfm_i.start();
		mip_bfm_i.wbyte({adr ^ 7'h01, 1'b0}, a);
		mip_bfm_i.stop();
		check("foreign address", 16'(a), 16'h0000);
		go(1);
		shunt <= 16'h8001;
		vbus <= 16'h1357;
		cur <= 16'habcd;
		pwr <= 16'h2468;
		for (int p = 3; p < 5; p++)
		begin
			wr(8'(p), 16'h0000, 0);
			rd("uncalibrated result", 16'h0000);
		end
		wr(mip_pkg::PTR_CALIB, 16'h1234, 3);
		check("calib write", cal, 16'h1234);
		rd("calib read", 16'h1234);
		rd("calib reread", 16'h1234);
		for (int p = 1; p < 5; p++)
		begin
			wr(8'(p), 16'h0000, 0);
			rd("result read", p == 1 ? shunt : p == 2 ? vbus : p == 3 ? pwr : cur);
		end
		mip_bfm_i.start();
		mip_bfm_i.wbyte({adr, 1'b1}, a);
		mip_bfm_i.rbyte(1'b0, h);
		go(40);
		check("high byte first", 16'(h), 16'h00ab);
		check("released after nack", 16'(sda_oe), 16'h0000);
		mip_bfm_i.stop();
		wr(mip_pkg::PTR_CONFIG, 16'h8000, 2);
		check("reset pulses", 16'(rst_seen), 16'h0001);
		check("config after reset", cfg, mip_pkg::CONFIG_RESET);
		check("calib after reset", cal, 16'h0000);
		rd("config read", mip_pkg::CONFIG_RESET);
		wr(mip_pkg::PTR_CONFIG, 16'h1122, 2);
		for (int c = 5; c < 7; c++)
		begin
			check("config before call", cfg, 16'h1122);
			mip_bfm_i.start();
			mip_bfm_i.wbyte(mip_pkg::GC_ADDR_BYTE, a);
			check("general call ack", 16'(a), 16'h0001);
			mip_bfm_i.wbyte(8'(c), a);
			check("call command ack", 16'(a), 16'(c == 6));
			mip_bfm_i.stop();
			go(20);
		end
		check("config after call", cfg, mip_pkg::CONFIG_RESET);
		check("call reset pulses", 16'(rst_seen), 16'h0002);
		mip_bfm_i.start();
		mip_bfm_i.wbyte(8'h0b, a);
		check("master code nack", 16'(a), 16'h0000);
		check("hs entered", 16'(hs), 16'h0001);
		mip_bfm_i.q = 24;
		wr(mip_pkg::PTR_CALIB, 16'h00a5, 2);
		mip_bfm_i.q = 100;
		check("hs calib", cal, 16'h00a5);
		check("hs left", 16'(hs), 16'h0000);
		mip_bfm_i.start();
		mip_bfm_i.wbyte({adr, 1'b1}, a);
		go(100);
		check("stalled read drives", 16'(sda_oe), 16'h0001);
		check("drive levels", {13'h0, scl_o, sda_o, scl_oe}, 16'h0000);
		go(2100);
		check("timeout release", 16'(sda_oe), 16'h0000);
		mip_bfm_i.stop();
		finish_test();
	end
endmodule // tb_top
`default_nettype wire
